// ===== verilog/fspc_pkg.sv
// shared constants and types of the flash self-program controller
package fspc_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int MIN_CPU_HZ = 1_000_000;
    localparam int HALT_REL_US = 10;
    localparam int HALT_REL_EXTRA = 2;
    localparam int HALT_REL_CYC = HALT_REL_US * (CLK_HZ / 1_000_000) + HALT_REL_EXTRA;
    localparam int SETTLE_US = 8;
    localparam int SETTLE_CYC = SETTLE_US * (CLK_HZ / 1_000_000);
    localparam logic CLK_OK = (CLK_HZ >= MIN_CPU_HZ);
    // device register indices on the link
    localparam logic [2:0] IDX_GATE = 3'h0;
    localparam logic [2:0] IDX_MODE = 3'h1;
    localparam logic [2:0] IDX_CMD = 3'h2;
    localparam logic [2:0] IDX_APL = 3'h3;
    localparam logic [2:0] IDX_APH = 3'h4;
    localparam logic [2:0] IDX_CPL = 3'h5;
    localparam logic [2:0] IDX_CPH = 3'h6;
    localparam logic [2:0] IDX_STAT = 3'h7;
    localparam logic [7:0] GATE_KEY = 8'hA5;
    localparam logic [7:0] CMD_NONE = 8'h00;
    localparam logic [7:0] CMD_WRITE = 8'h01;
    localparam logic [7:0] CMD_ERASE = 8'h03;
    localparam logic [7:0] CMD_VERIFY = 8'h04;
    localparam logic [7:0] CMD_BLANK = 8'h05;
    localparam logic [7:0] BLANK_BYTE = 8'hFF;
    localparam logic [7:0] MASK_ALL = 8'hFF;
    localparam logic [7:0] HIGH_KEEP = 8'h0F;
    localparam int MODE_SP_BIT = 0;
    localparam int STAT_ERR_BIT = 0;
    localparam int STAT_REJ_BIT = 1;
    // apb map of the cpu end
    localparam logic [7:0] OFS_DEV_ACCESS = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_CONFIG = 8'h08;
    localparam logic [7:0] OFS_IRQ_ACK = 8'h0C;
    localparam int DA_IDX_LSB = 8;
    localparam int CFG_EXT_BIT = 0;
    localparam int CFG_CLKOK_BIT = 1;
    localparam int CFG_MASK_LSB = 8;
    localparam int CFG_DI_BIT = 16;
    localparam int ST_IRQ_LSB = 8;
    localparam logic [7:0] SETTLE_CNT = 8'(SETTLE_CYC);
    localparam logic [7:0] HALT_CNT = 8'(HALT_REL_CYC);
    typedef enum logic [1:0] {OP_WRITE, OP_ERASE, OP_VERIFY, OP_BLANK} fspc_op_t;

    function automatic logic fspc_high_illegal(input logic [7:0] v);
        return |v[7:5];
    endfunction
endpackage

// ===== verilog/fspc_link_if.sv
// link between the cpu core end and the flash self-program device end
interface fspc_link_if;
    logic wr;
    logic [2:0] idx;
    logic [7:0] wdata;
    logic halt_req;
    logic [7:0] irq_ack;
    logic sp_mode;
    logic halted;
    logic stall;
    logic err;
    logic rej;
    logic [7:0] irq;
    modport dev (input wr, idx, wdata, halt_req, irq_ack, output sp_mode, halted, stall, err, rej, irq);
    modport cpu (output wr, idx, wdata, halt_req, irq_ack, input sp_mode, halted, stall, err, rej, irq);
endinterface

// ===== verilog/fspc_dev.sv
// device end: protected mode entry, halt release, command sequencing
// What this block does
// RULE1 - stall cpu while flash command runs
// RULE2 - program restarts watchdog before each command
// RULE3 - interrupts held pending during self-program mode
// RULE4 - program sets mask all ones, disables interrupts
// RULE5 - no ram access while command runs
// RULE6 - reset during write or erase: no guarantee
// RULE7 - erased bytes read as all ones
// RULE8 - cpu clock kept at least 1 MHz
// RULE9 - nop then halt right after mode entry
// RULE10 - halt released after 10 us plus 2 clocks
// RULE11 - wait 8 us after release on crystal
// RULE12 - error flag read as single bit only
// RULE13 - pins hold halt state in self-program mode
// RULE14 - external security settings ignored in this mode
// RULE15 - protect byte blocks write and erase
// RULE16 - program clears bits 7:4 of high pointers
// RULE17 - high pointer bits 7:5 set: command undefined
// RULE18 - program zeroes command register around mode switch; cpu end clears it only before the gate write
// RULE19 - no interrupt serviced in self-program mode
// RULE20 - mode changes only via protected sequence, else error
//
// Implementation choices: register access over APB and the placing of the registers.
module fspc_dev
    import fspc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    fspc_link_if.dev link,
    input wire logic [7:0] irq_in,
    input wire logic [3:0] protect_byte,
    input wire logic security_lock,
    input wire logic fl_done,
    output logic fl_req_q,
    output fspc_op_t fl_op_q,
    output logic [3:0] fl_block_q,
    output logic [7:0] fl_addr_lo_q,
    output logic [7:0] fl_end_lo_q,
    output logic [7:0] fl_wdata_q,
    output logic ram_access_ok_q,
    output logic pin_hold_q,
    output logic ext_lock_q
);
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_MODE1, SEQ_MODE2, SEQ_MODE3} fspc_seq_t;
    typedef enum logic [1:0] {ST_NORMAL, ST_SP_HALT, ST_SP_READY, ST_SP_BUSY} fspc_st_t;

    fspc_seq_t seq_q, seq_d;
    fspc_st_t st_q;
    logic [7:0] seq_val_q;
    logic seq_err, seq_commit;
    logic mode_q;
    logic [7:0] cmd_q, apl_q, aph_q, cpl_q, cph_q;
    logic err_q, rej_q;
    logic [7:0] halt_cnt_q;
    logic [7:0] pend_q;
    logic stall_q, halted_q;
    logic [7:0] irq_q;
    logic cmd_go, cmd_bad, cmd_prot, is_modify;

    // protected mode-change sequence: key, value, inverse, value
    always_comb begin
        seq_d = seq_q;
        seq_err = 1'b0;
        seq_commit = 1'b0;
        if (link.wr) begin
            if (link.idx == IDX_GATE) begin
                seq_d = (link.wdata == GATE_KEY) ? SEQ_MODE1 : SEQ_IDLE; // [RULE20]
                seq_err = (link.wdata != GATE_KEY);
            end else if (link.idx == IDX_MODE) begin
                case (seq_q)
                    SEQ_MODE1: seq_d = SEQ_MODE2;
                    SEQ_MODE2: begin
                        seq_d = (link.wdata == ~seq_val_q) ? SEQ_MODE3 : SEQ_IDLE;
                        seq_err = (link.wdata != ~seq_val_q);
                    end
                    SEQ_MODE3: begin
                        seq_d = SEQ_IDLE;
                        seq_err = (link.wdata != seq_val_q);
                        seq_commit = (link.wdata == seq_val_q); // [RULE20]
                    end
                    default: begin
                        seq_d = SEQ_IDLE;
                        seq_err = 1'b1;
                    end
                endcase
            end else if (seq_q != SEQ_IDLE) begin
                seq_d = SEQ_IDLE;
                seq_err = 1'b1; // [RULE20]
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_q <= SEQ_IDLE;
            seq_val_q <= 8'h00;
        end else begin
            seq_q <= seq_d;
            if (link.wr && link.idx == IDX_MODE && seq_q == SEQ_MODE1) begin
                seq_val_q <= link.wdata;
            end
        end
    end

    // plain registers; the cpu end keeps the upper pointer bits clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q <= CMD_NONE;
            apl_q <= 8'h00;
            aph_q <= 8'h00;
            cpl_q <= 8'h00;
            cph_q <= 8'h00;
        end else if (link.wr) begin
            case (link.idx)
                IDX_CMD: cmd_q <= link.wdata;
                IDX_APL: apl_q <= link.wdata;
                IDX_APH: aph_q <= link.wdata;
                IDX_CPL: cpl_q <= link.wdata;
                IDX_CPH: cph_q <= link.wdata;
                default: ;
            endcase
        end
    end

    // command launch checks; security_lock is not looked at here
    always_comb begin
        is_modify = (link.wdata == CMD_WRITE) || (link.wdata == CMD_ERASE);
        cmd_go = link.wr && link.idx == IDX_CMD && link.wdata != CMD_NONE && st_q == ST_SP_READY; // [RULE14]
        // undefined on the real part; refusing is the safe reading
        cmd_bad = fspc_high_illegal(aph_q) || fspc_high_illegal(cph_q); // [RULE17]
        cmd_prot = is_modify && (aph_q[3:0] < protect_byte); // [RULE15]
    end

    // set wins over a software clear of the same flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_q <= 1'b0;
            rej_q <= 1'b0;
        end else begin
            if (seq_err) begin
                err_q <= 1'b1; // [RULE20]
            end else if (link.wr && link.idx == IDX_STAT && !link.wdata[STAT_ERR_BIT]) begin
                err_q <= 1'b0;
            end
            if (cmd_go && (cmd_bad || cmd_prot)) begin
                rej_q <= 1'b1; // [RULE15]
            end else if (link.wr && link.idx == IDX_STAT && !link.wdata[STAT_REJ_BIT]) begin
                rej_q <= 1'b0;
            end
        end
    end

    // mode state, halt release timer, command run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // an interrupted write or erase is simply dropped
            st_q <= ST_NORMAL; // [RULE6]
            mode_q <= 1'b0;
            halt_cnt_q <= 8'h00;
            stall_q <= 1'b0;
            halted_q <= 1'b0;
            fl_req_q <= 1'b0;
            fl_op_q <= OP_WRITE;
            fl_block_q <= 4'h0;
            fl_addr_lo_q <= 8'h00;
            fl_end_lo_q <= 8'h00;
            fl_wdata_q <= 8'h00;
        end else begin
            case (st_q)
                ST_NORMAL: begin
                    if (seq_commit && seq_val_q[MODE_SP_BIT]) begin
                        mode_q <= 1'b1;
                        st_q <= ST_SP_READY;
                    end
                end
                ST_SP_READY: begin
                    if (seq_commit && !seq_val_q[MODE_SP_BIT]) begin
                        mode_q <= 1'b0;
                        st_q <= ST_NORMAL;
                    end else if (link.halt_req) begin
                        halted_q <= 1'b1;
                        halt_cnt_q <= HALT_CNT;
                        st_q <= ST_SP_HALT;
                    end else if (cmd_go && !cmd_bad && !cmd_prot) begin
                        stall_q <= 1'b1; // [RULE1]
                        fl_req_q <= 1'b1;
                        fl_block_q <= aph_q[3:0];
                        fl_addr_lo_q <= apl_q;
                        fl_end_lo_q <= cpl_q;
                        fl_wdata_q <= BLANK_BYTE; // [RULE7]
                        case (link.wdata)
                            CMD_ERASE: fl_op_q <= OP_ERASE; // [RULE7]
                            CMD_VERIFY: fl_op_q <= OP_VERIFY;
                            CMD_BLANK: fl_op_q <= OP_BLANK;
                            default: fl_op_q <= OP_WRITE;
                        endcase
                        st_q <= ST_SP_BUSY;
                    end
                end
                ST_SP_HALT: begin
                    // fixed worst-case release so software timing is deterministic
                    if (halt_cnt_q == 8'h01) begin
                        halted_q <= 1'b0; // [RULE10]
                        st_q <= ST_SP_READY;
                    end
                    halt_cnt_q <= halt_cnt_q - 8'h01;
                end
                ST_SP_BUSY: begin
                    if (fl_done) begin
                        fl_req_q <= 1'b0;
                        stall_q <= 1'b0; // [RULE1]
                        st_q <= ST_SP_READY;
                    end
                end
                default: st_q <= ST_NORMAL;
            endcase
        end
    end

    // interrupt holding and side outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 8'h00;
            irq_q <= 8'h00;
            ram_access_ok_q <= 1'b1;
            pin_hold_q <= 1'b0;
            ext_lock_q <= 1'b0;
        end else begin
            pend_q <= (pend_q & ~link.irq_ack) | irq_in; // [RULE3]
            irq_q <= mode_q ? 8'h00 : pend_q; // [RULE19]
            ram_access_ok_q <= (st_q != ST_SP_BUSY); // [RULE5]
            pin_hold_q <= mode_q; // [RULE13]
            ext_lock_q <= security_lock && !mode_q; // [RULE14]
        end
    end

    assign link.sp_mode = mode_q;
    assign link.halted = halted_q;
    assign link.stall = stall_q;
    assign link.err = err_q;
    assign link.rej = rej_q;
    assign link.irq = irq_q;
endmodule // fspc_dev

// ===== verilog/fspc_cpu.sv
// cpu end: apb-driven register writes with the program-side obligations
module fspc_cpu
    import fspc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic wdt_restart_q,
    fspc_link_if.cpu link
);
    typedef enum logic [3:0] {C_IDLE, C_PRECLR, C_SEND, C_LAG, C_CHECK, C_NOP, C_HALT, C_HALTED, C_SETTLE, C_DONE}
        fspc_cst_t;

    fspc_cst_t cs_q;
    logic [2:0] idx_q;
    logic [7:0] data_q;
    logic was_sp_q;
    logic [7:0] cnt_q;
    logic ext_clk_q, di_q;
    logic [7:0] mask_q;
    logic wr_q, halt_q;
    logic [7:0] ack_q;
    logic [31:0] rdata_q;
    logic ready_q, slverr_q;
    logic start;

    assign start = psel && penable && !ready_q && cs_q == C_IDLE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_q <= C_IDLE;
            idx_q <= 3'h0;
            data_q <= 8'h00;
            was_sp_q <= 1'b0;
            cnt_q <= 8'h00;
            ext_clk_q <= 1'b0;
            di_q <= 1'b0;
            mask_q <= 8'h00;
            wr_q <= 1'b0;
            halt_q <= 1'b0;
            ack_q <= 8'h00;
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b0;
            slverr_q <= 1'b0;
            wdt_restart_q <= 1'b0;
        end else begin
            wr_q <= 1'b0;
            halt_q <= 1'b0;
            ack_q <= 8'h00;
            ready_q <= 1'b0;
            wdt_restart_q <= 1'b0;
            case (cs_q)
                C_IDLE: begin
                    if (start) begin
                        slverr_q <= 1'b0;
                        cs_q <= C_DONE;
                        if (pwrite && paddr == OFS_DEV_ACCESS) begin
                            idx_q <= pwdata[DA_IDX_LSB +: 3];
                            data_q <= pwdata[7:0];
                            was_sp_q <= link.sp_mode;
                            if (pwdata[DA_IDX_LSB +: 3] == IDX_APH || pwdata[DA_IDX_LSB +: 3] == IDX_CPH) begin
                                data_q <= pwdata[7:0] & HIGH_KEEP; // [RULE16]
                            end
                            if (pwdata[DA_IDX_LSB +: 3] == IDX_GATE) begin
                                mask_q <= MASK_ALL; // [RULE4]
                                di_q <= 1'b1; // [RULE4]
                                cs_q <= C_PRECLR;
                            end else begin
                                cs_q <= C_SEND;
                            end
                            if (pwdata[DA_IDX_LSB +: 3] == IDX_CMD && pwdata[7:0] != CMD_NONE) begin
                                wdt_restart_q <= 1'b1; // [RULE2]
                            end
                        end else if (pwrite && paddr == OFS_CONFIG) begin
                            ext_clk_q <= pwdata[CFG_EXT_BIT];
                            mask_q <= pwdata[CFG_MASK_LSB +: 8];
                            di_q <= pwdata[CFG_DI_BIT];
                        end else if (pwrite && paddr == OFS_IRQ_ACK) begin
                            ack_q <= pwdata[7:0];
                        end else if (!pwrite && paddr == OFS_STATUS) begin
                            // error flag carried as its own bit only
                            rdata_q <= {16'h0000, link.irq & ~mask_q, 3'h0, link.rej, link.err, // [RULE12]
                                        link.stall, link.halted, link.sp_mode};
                        end else if (!pwrite && paddr == OFS_CONFIG) begin
                            rdata_q <= {15'h0000, di_q, mask_q, 6'h00, CLK_OK, ext_clk_q}; // [RULE8]
                        end else if (paddr != OFS_CONFIG && paddr != OFS_IRQ_ACK) begin
                            slverr_q <= 1'b1;
                        end
                    end
                end
                C_PRECLR: begin
                    // command register zeroed before every mode switch
                    wr_q <= 1'b1;
                    cs_q <= C_SEND;
                end
                C_SEND: begin
                    if (!link.stall && !link.halted) begin
                        wr_q <= 1'b1;
                        cs_q <= C_LAG;
                    end
                end
                // link flags answer one edge after the write lands
                C_LAG: cs_q <= C_CHECK;
                C_CHECK: begin
                    if (!link.stall) begin
                        cs_q <= (link.sp_mode && !was_sp_q) ? C_NOP : C_DONE;
                    end
                end
                C_NOP: cs_q <= C_HALT; // [RULE9]
                C_HALT: begin
                    halt_q <= 1'b1; // [RULE9]
                    cs_q <= C_HALTED;
                end
                C_HALTED: begin
                    if (halt_q || link.halted) begin
                        cs_q <= C_HALTED;
                    end else if (ext_clk_q) begin
                        cnt_q <= SETTLE_CNT;
                        cs_q <= C_SETTLE;
                    end else begin
                        cs_q <= C_DONE;
                    end
                end
                C_SETTLE: begin
                    if (cnt_q == 8'h01) begin
                        cs_q <= C_DONE; // [RULE11]
                    end
                    cnt_q <= cnt_q - 8'h01;
                end
                C_DONE: begin
                    ready_q <= 1'b1;
                    cs_q <= C_IDLE;
                end
                default: cs_q <= C_IDLE;
            endcase
        end
    end

    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = slverr_q;
    assign link.wr = wr_q;
    assign link.idx = (cs_q == C_SEND && wr_q) ? IDX_CMD : idx_q; // [RULE18]
    assign link.wdata = (cs_q == C_SEND && wr_q) ? CMD_NONE : data_q; // [RULE18]
    assign link.halt_req = halt_q;
    assign link.irq_ack = ack_q;
endmodule // fspc_cpu

// ===== dv/fspc_link_monitor.sv
// link checker of the flash self-program controller
module fspc_link_monitor
    import fspc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr,
    input wire logic [2:0] idx,
    input wire logic [7:0] wdata,
    input wire logic halt_req,
    input wire logic [7:0] irq_ack,
    input wire logic sp_mode,
    input wire logic halted,
    input wire logic stall,
    input wire logic err,
    input wire logic rej,
    input wire logic [7:0] irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] hcnt_q;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // halt span far beyond 8 cycles, so counted here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hcnt_q <= 8'h00;
        end else begin
            hcnt_q <= halted ? hcnt_q + 8'h01 : 8'h00;
        end
    end
    sequence s_cmd;
        wr && idx == IDX_CMD && wdata != CMD_NONE && sp_mode && !halted && !stall;
    endsequence
    sequence s_preclr;
        wr && idx == IDX_CMD && wdata == CMD_NONE;
    endsequence
    AST_LAUNCH: assert property (s_cmd |=> stall || rej) else $error("command neither run nor refused");
    AST_PRECLR: assert property (wr && idx == IDX_GATE |-> $past(wr) && $past(idx) == IDX_CMD
        && $past(wdata) == CMD_NONE) else $error("gate write without command clear");
    AST_HALT_LEN: assert property ($fell(halted) |-> hcnt_q == HALT_CNT) else $error("halt span wrong");
    AST_HALT_MAX: assert property (halted |-> hcnt_q < HALT_CNT) else $error("halt span too long");
    AST_HALT_SP: assert property ($rose(halted) |-> sp_mode) else $error("halt outside mode");
    AST_IRQ_HOLD: assert property (sp_mode && $past(sp_mode) |-> irq == 8'h00) else $error("irq in mode");
    AST_ERR_CAUSE: assert property ($rose(err) |-> $past(wr) || $past(wr, 2)) else $error("error flag uncaused");
    AST_STALL_SP: assert property (stall |-> sp_mode) else $error("stall outside mode");
    AST_REJ_QUIET: assert property ($rose(rej) |-> !stall) else $error("refused command launched");
    AST_NO_HALT_CMD: assert property (halted |-> !$rose(stall)) else $error("command during halt");
    cover property (s_preclr ##1 (wr && idx == IDX_GATE));
endmodule // fspc_link_monitor

// ===== dv/tb_top.sv
// self-checking bench of the flash self-program controller
module tb_top
    import fspc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic rd; logic [31:0] d; logic [31:0] m; logic e;} fspc_exp_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, wdt_restart_q, fl_req_q, ram_access_ok_q, pin_hold_q, ext_lock_q, refused;
    logic [7:0] irq_in = 8'h00;
    logic [3:0] protect_byte = 4'h0;
    logic security_lock = 1'b0;
    logic fl_done = 1'b0;
    logic wdt_seen = 1'b0;
    fspc_op_t fl_op_q, exp_op;
    logic [3:0] fl_block_q, exp_blk;
    logic [7:0] fl_addr_lo_q, fl_end_lo_q, fl_wdata_q, r, r2;
    int n_fail = 0, comparisons = 0, launches = 0, exp_launch = 0, busy_n = 0, cyc, k, dly = 4;
    logic [7:0] codes [4] = '{CMD_WRITE, CMD_ERASE, CMD_VERIFY, CMD_BLANK};
    fspc_op_t ops [4] = '{OP_WRITE, OP_ERASE, OP_VERIFY, OP_BLANK};
    fspc_exp_t q [$];
    fspc_exp_t cur;
    fspc_link_if fspc_link_if_i();
    fspc_cpu fspc_cpu_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wdt_restart_q(wdt_restart_q), .link(fspc_link_if_i));
    fspc_dev fspc_dev_i (.pclk(pclk), .presetn(presetn), .link(fspc_link_if_i), .irq_in(irq_in),
        .protect_byte(protect_byte), .security_lock(security_lock), .fl_done(fl_done), .fl_req_q(fl_req_q),
        .fl_op_q(fl_op_q), .fl_block_q(fl_block_q), .fl_addr_lo_q(fl_addr_lo_q), .fl_end_lo_q(fl_end_lo_q),
        .fl_wdata_q(fl_wdata_q), .ram_access_ok_q(ram_access_ok_q), .pin_hold_q(pin_hold_q),
        .ext_lock_q(ext_lock_q));
    fspc_link_monitor fspc_link_monitor_i (.pclk(pclk), .presetn(presetn), .wr(fspc_link_if_i.wr),
        .idx(fspc_link_if_i.idx), .wdata(fspc_link_if_i.wdata), .halt_req(fspc_link_if_i.halt_req),
        .irq_ack(fspc_link_if_i.irq_ack), .sp_mode(fspc_link_if_i.sp_mode), .halted(fspc_link_if_i.halted),
        .stall(fspc_link_if_i.stall), .err(fspc_link_if_i.err), .rej(fspc_link_if_i.rej),
        .irq(fspc_link_if_i.irq));
    initial begin
        forever #50 pclk = ~pclk;
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // expectation queued before the setup cycle so the watcher never sees an answer first
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] ed,
        input logic [31:0] m, input logic e);
        q.push_back('{~w, ed, m, e});
        cyc = 0;
        @(posedge pclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            cyc++;
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr32(input logic [7:0] a, input logic [31:0] d, input logic e);
        apb(a, 1'b1, d, 32'h0, 32'h0, e);
    endtask
    task automatic rd32(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] m);
        apb(a, 1'b0, 32'h0, ed, m, 1'b0);
    endtask
    task automatic dev(input logic [2:0] i, input logic [7:0] d);
        wr32(OFS_DEV_ACCESS, {21'h0, i, d}, 1'b0);
    endtask
    task automatic st(input logic [31:0] e);
        rd32(OFS_STATUS, e, 32'h1F);
    endtask
    task automatic pulse(input logic [7:0] v);
        @(posedge pclk);
        irq_in <= v;
        @(posedge pclk);
        irq_in <= 8'h00;
        @(posedge pclk);
    endtask
    task automatic idle();
        int n;
        n = 0;
        while (fspc_link_if_i.stall !== 1'b0 && n < 500) begin
            @(posedge pclk);
            n++;
        end
    endtask
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            if (q.size() == 0) begin
                cmp(32'h1, 32'h0);
            end else begin
                cur = q.pop_front();
                cmp({31'h0, pslverr}, {31'h0, cur.e});
                if (cur.rd) begin
                    cmp(prdata & cur.m, cur.d & cur.m);
                end
            end
        end
    end
    // flash array stand-in: answers after a random delay
    always @(posedge pclk) begin
        fl_done <= 1'b0;
        if (wdt_restart_q === 1'b1) begin
            wdt_seen <= 1'b1;
        end
        if (fl_req_q === 1'b1) begin
            busy_n <= busy_n + 1;
            if (busy_n == 2) begin
                launches++;
                wdt_seen <= 1'b0;
                cmp({31'h0, wdt_seen}, 32'h1);
                cmp({30'h0, fl_op_q}, {30'h0, exp_op});
                cmp({28'h0, fl_block_q}, {28'h0, exp_blk});
                cmp({24'h0, fl_wdata_q}, {24'h0, BLANK_BYTE});
                cmp({31'h0, ram_access_ok_q}, 32'h0);
                cmp({31'h0, fspc_link_if_i.stall}, 32'h1);
            end
            if (busy_n == dly) begin
                fl_done <= 1'b1;
            end
        end else begin
            busy_n <= 0;
        end
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        results();
    end
    initial begin
        cyc = $urandom(32'hE623);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        cmp({31'h0, ram_access_ok_q}, 32'h1);
        rd32(OFS_CONFIG, 32'h2, 32'h1FF03);
        dev(IDX_MODE, 8'h01);
        st(32'h8);
        dev(IDX_STAT, 8'h00);
        dev(IDX_GATE, 8'h5A);
        st(32'h8);
        dev(IDX_STAT, 8'h00);
        dev(IDX_GATE, GATE_KEY);
        dev(IDX_MODE, 8'h01);
        dev(IDX_MODE, 8'h01);
        st(32'h8);
        dev(IDX_STAT, 8'h00);
        st(32'h0);
        r = 8'($urandom_range(1, 255));
        r2 = 8'($urandom_range(1, 255));
        wr32(OFS_CONFIG, 32'h1, 1'b0);
        pulse(r);
        rd32(OFS_STATUS, {16'h0, r, 8'h00}, 32'hFF1F);
        security_lock <= 1'b1;
        dev(IDX_GATE, GATE_KEY);
        dev(IDX_MODE, 8'h01);
        dev(IDX_MODE, 8'hFE);
        dev(IDX_MODE, 8'h01);
        cmp({31'h0, cyc >= HALT_REL_CYC + SETTLE_CYC}, 32'h1);
        rd32(OFS_CONFIG, 32'h1FF03, 32'h1FF03);
        st(32'h1);
        cmp({30'h0, pin_hold_q, ext_lock_q}, 32'h2);
        pulse(r2);
        cmp({24'h0, fspc_link_if_i.irq}, 32'h0);
        for (int i = 0; i < 12; i++) begin
            k = i % 4;
            exp_blk = 4'($urandom_range(0, 15));
            protect_byte <= 4'($urandom_range(0, 15));
            dly = $urandom_range(3, 40);
            exp_op = ops[k];
            dev(IDX_APH, {4'($urandom), exp_blk});
            dev(IDX_CPH, {4'h0, exp_blk});
            dev(IDX_CMD, codes[k]);
            refused = k < 2 && exp_blk < protect_byte;
            exp_launch += refused ? 0 : 1;
            idle();
            st({27'h0, refused, 4'h1});
            dev(IDX_STAT, 8'h00);
            dev(IDX_CMD, CMD_NONE);
        end
        cmp(32'(launches), 32'(exp_launch));
        dev(IDX_GATE, GATE_KEY);
        dev(IDX_MODE, 8'h00);
        dev(IDX_MODE, 8'hFF);
        dev(IDX_MODE, 8'h00);
        st(32'h0);
        cmp({30'h0, pin_hold_q, ext_lock_q}, 32'h1);
        wr32(OFS_CONFIG, 32'h0, 1'b0);
        rd32(OFS_STATUS, {16'h0, r | r2, 8'h00}, 32'hFF1F);
        wr32(OFS_IRQ_ACK, 32'hFF, 1'b0);
        rd32(OFS_STATUS, 32'h0, 32'hFF1F);
        wr32(OFS_STATUS, 32'h0, 1'b1);
        apb(8'h40, 1'b0, 32'h0, 32'h0, 32'h0, 1'b1);
        repeat (2) @(posedge pclk);
        results();
    end
endmodule // tb_top
